// >>> bench/parallel_ports_a_to_d_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_ports_a_to_d_bench;
   logic clk = 1'b0;
   logic rstB = 1'b0;
   logic expandedMode = 1'b0;
   logic hwrite = 1'b0;
   logic [5:0] haddr = 6'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = gpio_pkg::HSIZE_WORD;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp;
   logic [7:0] pIn [4];
   logic [7:0] pOut [4];
   logic [7:0] pOe [4];
   logic [7:0] board [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hE7};
   logic [7:0] lat [4] = '{8'hA5, 8'h5A, 8'h3C, 8'h69};
   logic [5:0] dataAddr [4] = '{6'h00, 6'h10, 6'h18, 6'h20};
   logic [5:0] dirAddr [4] = '{6'h04, 6'h08, 6'h1C, 6'h24};
   logic [7:0] timerEn = 8'h00, timerOut = 8'h00, timerOe = 8'h00, timerIn;
   logic [7:0] serialEn = 8'h00, serialOut = 8'h00, serialOe = 8'h00, serialIn;
   logic [7:0] busDataOut = 8'h96, busDataOe = 8'h0F, busDataIn;
   int fails = 0;
   int samplesChecked = 0;
   int cycles = 0;

   always #12.5 clk = ~clk;

   parallel_ports dut (.clk(clk), .rst_b(rstB), .ce(1'b1), .expandedMode(expandedMode),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .portAIn(pIn[0]), .portAOut(pOut[0]), .portAOe(pOe[0]),
      .portBIn(pIn[1]), .portBOut(pOut[1]), .portBOe(pOe[1]), .portCIn(pIn[2]),
      .portCOut(pOut[2]), .portCOe(pOe[2]), .portDIn(pIn[3]), .portDOut(pOut[3]),
      .portDOe(pOe[3]), .timerEn(timerEn), .timerOut(timerOut), .timerOe(timerOe),
      .timerIn(timerIn), .addrHigh(8'h81), .busDataOut(busDataOut), .busDataOe(busDataOe),
      .busDataIn(busDataIn), .serialEn(serialEn), .serialOut(serialOut),
      .serialOe(serialOe), .serialIn(serialIn));

   for (genvar g = 0; g < 4; g++) begin : g_board
      pin_board board_i (.drvOut(pOut[g]), .drvOe(pOe[g]), .boardLevel(board[g]),
         .pinLevel(pIn[g]));
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single word transfer; waits on the slave, never on a fixed count
   task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] wd);
      @(posedge clk);
      htrans <= gpio_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk("response", {31'h0, hresp}, {31'h0, gpio_pkg::HRESP_OKAY});
   endtask

   task automatic rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(what, rd, {24'h000000, exp});
   endtask

   // pins follow one edge after the register update
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         final_report;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rstB <= 1'b1;
      settle;
      for (int i = 0; i < 4; i++) begin
         chk("pin enable after reset", pOe[i], 8'h00);
         rdchk("direction reset", dirAddr[i], 8'h00);
      end
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, dataAddr[i], lat[i]);
         acc(1'b1, dirAddr[i], 8'hF0);
         rdchk("mixed read", dataAddr[i], (lat[i] & 8'hF0) | (board[i] & 8'h0F));
      end
      settle;
      for (int i = 0; i < 4; i++) begin
         chk("drive enable", pOe[i], 8'hF0);
         chk("drive level", pOut[i] & 8'hF0, lat[i] & 8'hF0);
      end
      $display("test direction done");
      acc(1'b0, 6'h00, 8'h00);
      rstB <= 1'b0;
      repeat (2) @(posedge clk);
      rstB <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdchk("direction after reset", dirAddr[i], 8'h00);
         acc(1'b1, dirAddr[i], 8'hFF);
         rdchk("latch kept", dataAddr[i], lat[i]);
      end
      $display("test retention done");
      timerEn <= 8'h0F;
      timerOut <= 8'h0A;
      timerOe <= 8'h08;
      acc(1'b1, 6'h00, 8'h00);
      serialEn <= 8'hC0;
      serialOut <= 8'h80;
      serialOe <= 8'h80;
      settle;
      chk("timer enable", pOe[0], 8'hF8);
      chk("timer level", pOut[0] & pOe[0], 8'h08);
      chk("capture input", timerIn & 8'h07, 8'h04);
      chk("serial enable", pOe[3], 8'hBF);
      chk("serial level", pOut[3] & pOe[3], 8'hA9);
      chk("serial input", serialIn & 8'h40, 8'h40);
      rdchk("owned latch stored", 6'h00, 8'h00);
      $display("test alternate done");
      expandedMode <= 1'b1;
      settle;
      chk("address pins", pOut[1], 8'h81);
      chk("address enable", pOe[1], 8'hFF);
      chk("bus enable", pOe[2], 8'h0F);
      chk("bus level", pOut[2] & 8'h0F, 8'h06);
      chk("bus input", busDataIn, 8'h56);
      rdchk("hidden register", 6'h08, 8'h00);
      acc(1'b1, 6'h1C, 8'h00);
      expandedMode <= 1'b0;
      rdchk("ignored write", 6'h1C, 8'hFF);
      rdchk("unmapped", 6'h3C, 8'h00);
      $display("test mode done");
      final_report;
   end
endmodule // parallel_ports_a_to_d_bench
`default_nettype wire

// >>> bench/pin_board.sv
`timescale 1ns/1ps
`default_nettype none
module pin_board (
   input wire logic [7:0] drvOut, // device drive level
   input wire logic [7:0] drvOe, // device drive enable
   input wire logic [7:0] boardLevel, // level the board applies
   output logic [7:0] pinLevel // resolved pin level
);
   // board sources are resistive, so an enabled device driver wins
   assign pinLevel = (drvOut & drvOe) | (boardLevel & ~drvOe);
endmodule // pin_board
`default_nettype wire

// >>> rtl/gpio_pkg.sv
package gpio_pkg;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 4;
   localparam int IDX_W = 4;
   // register indices; byte address is four times the index
   localparam int IDX_LSB = 2;
   localparam logic [3:0] IDX_A_DATA = 4'h0;
   localparam logic [3:0] IDX_A_DIR = 4'h1;
   localparam logic [3:0] IDX_B_DIR = 4'h2;
   localparam logic [3:0] IDX_B_DATA = 4'h4;
   localparam logic [3:0] IDX_C_DATA = 4'h6;
   localparam logic [3:0] IDX_C_DIR = 4'h7;
   localparam logic [3:0] IDX_D_DATA = 4'h8;
   localparam logic [3:0] IDX_D_DIR = 4'h9;
   // port numbers inside the packed port arrays
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;
   localparam logic [1:0] PORT_D = 2'h3;
   // reset values, plus the all-output enable and read data padding
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] OE_RESET = 8'h00;
   localparam logic [7:0] ALL_OUT = 8'hFF;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;
   localparam logic [23:0] RDATA_PAD = 24'h000000;
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// >>> rtl/parallel_ports.sv
// Operation
// RL1 - first port latch kept across reset
// RL2 - latch writes stored but alternate owns pin
// RL3 - direction set means output, resets zero
// RL4 - ports one and four reset as inputs
// RL5 - reset inputs float, latches undefined
// RL6 - first port pins shared with timer
// RL7 - expanded mode: second port drives high address
// RL8 - single-chip: second port resets as inputs
// RL9 - second and third latches kept across reset
// RL10 - expanded mode: third port is data bus
// RL11 - single-chip: third port resets as inputs
// RL12 - fourth port pins shared with serial, SPI
// RL13 - fourth port latch and direction registers
// RL14 - data read: latch for outputs, pin otherwise
// RL15 - mode input steers ports two, three, decode
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module parallel_ports #(
   parameter int ADDR_W = 6
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic expandedMode, // 1 = expanded or test, 0 = single-chip or bootstrap
   input wire logic hsel, // AHB-Lite slave select
   input wire logic [ADDR_W-1:0] haddr, // AHB-Lite byte address
   input wire logic [1:0] htrans, // AHB-Lite transfer type
   input wire logic hwrite, // AHB-Lite write
   input wire logic [2:0] hsize, // AHB-Lite size
   input wire logic [31:0] hwdata, // AHB-Lite write data
   input wire logic hready, // AHB-Lite bus ready
   output logic [31:0] hrdata, // AHB-Lite read data
   output logic hreadyout, // AHB-Lite slave ready
   output logic hresp, // AHB-Lite response, always OKAY
   input wire logic [7:0] portAIn, // first port pin levels
   output logic [7:0] portAOut, // first port drive levels
   output logic [7:0] portAOe, // first port drive enables
   input wire logic [7:0] portBIn, // second port pin levels
   output logic [7:0] portBOut, // second port drive levels
   output logic [7:0] portBOe, // second port drive enables
   input wire logic [7:0] portCIn, // third port pin levels
   output logic [7:0] portCOut, // third port drive levels
   output logic [7:0] portCOe, // third port drive enables
   input wire logic [7:0] portDIn, // fourth port pin levels
   output logic [7:0] portDOut, // fourth port drive levels
   output logic [7:0] portDOe, // fourth port drive enables
   input wire logic [7:0] timerEn, // timer owns first port bit
   input wire logic [7:0] timerOut, // compare outputs per bit
   input wire logic [7:0] timerOe, // timer drives bit (compare), else capture input
   output logic [7:0] timerIn, // sampled first port levels for captures
   input wire logic [7:0] addrHigh, // address bits 8 to 15 for expanded mode
   input wire logic [7:0] busDataOut, // external data bus write data
   input wire logic [7:0] busDataOe, // external data bus drive enable
   output logic [7:0] busDataIn, // sampled external data bus
   input wire logic [7:0] serialEn, // serial or SPI owns fourth port bit
   input wire logic [7:0] serialOut, // serial and SPI drive levels
   input wire logic [7:0] serialOe, // serial and SPI drive enables
   output logic [7:0] serialIn // sampled fourth port levels for receivers
);
   localparam int NP = gpio_pkg::NUM_PORTS;
   localparam int PW = gpio_pkg::PORT_W;
   localparam int TOP_SHIFT = gpio_pkg::IDX_LSB + gpio_pkg::IDX_W;

   typedef struct packed {
      logic [NP-1:0][PW-1:0] latch;
      logic [NP-1:0][PW-1:0] dir;
      logic [NP-1:0][PW-1:0] pinOut;
      logic [NP-1:0][PW-1:0] pinOe;
      logic [NP-1:0][PW-1:0] pinSample;
      logic wrPend;
      logic [gpio_pkg::IDX_W-1:0] wrIdx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   logic [NP-1:0][PW-1:0] altEn;
   logic [NP-1:0][PW-1:0] altOut;
   logic [NP-1:0][PW-1:0] altOe;
   logic [NP-1:0][PW-1:0] sliceOut;
   logic [NP-1:0][PW-1:0] sliceOe;
   logic [NP-1:0][PW-1:0] readVal;
   logic addrTaken;
   logic [gpio_pkg::IDX_W-1:0] busIdx;
   logic busInWindow;

   if (ADDR_W < TOP_SHIFT) begin : g_chk
      $error("ADDR_W too small for the register window");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode: {valid, isDir, port}; second and third ports vanish when expanded
   function automatic logic [3:0] regDecode(input logic [3:0] idx, input logic expanded);
      logic [3:0] r;
      r = 4'h0;
      case (idx)
         gpio_pkg::IDX_A_DATA: r = {2'b10, gpio_pkg::PORT_A}; // RL1
         gpio_pkg::IDX_A_DIR: r = {2'b11, gpio_pkg::PORT_A}; // RL3
         gpio_pkg::IDX_B_DIR: r = {!expanded, 1'b1, gpio_pkg::PORT_B}; // RL7
         gpio_pkg::IDX_B_DATA: r = {!expanded, 1'b0, gpio_pkg::PORT_B}; // RL9
         gpio_pkg::IDX_C_DATA: r = {!expanded, 1'b0, gpio_pkg::PORT_C}; // RL10
         gpio_pkg::IDX_C_DIR: r = {!expanded, 1'b1, gpio_pkg::PORT_C}; // RL15
         gpio_pkg::IDX_D_DATA: r = {2'b10, gpio_pkg::PORT_D}; // RL13
         gpio_pkg::IDX_D_DIR: r = {2'b11, gpio_pkg::PORT_D}; // RL13
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin ownership per port
   always_comb begin
      altEn[gpio_pkg::PORT_A] = timerEn; // RL6
      altOut[gpio_pkg::PORT_A] = timerOut;
      altOe[gpio_pkg::PORT_A] = timerOe;
      altEn[gpio_pkg::PORT_B] = {PW{expandedMode}}; // RL7
      altOut[gpio_pkg::PORT_B] = addrHigh;
      altOe[gpio_pkg::PORT_B] = gpio_pkg::ALL_OUT;
      altEn[gpio_pkg::PORT_C] = {PW{expandedMode}}; // RL10
      altOut[gpio_pkg::PORT_C] = busDataOut;
      altOe[gpio_pkg::PORT_C] = busDataOe;
      altEn[gpio_pkg::PORT_D] = serialEn; // RL12
      altOut[gpio_pkg::PORT_D] = serialOut;
      altOe[gpio_pkg::PORT_D] = serialOe;
   end

   for (genvar g = 0; g < NP; g++) begin : g_port
      port_slice #(
         .W(PW)
      ) u_slice (
         .latch(st_ff.latch[g]),
         .dir(st_ff.dir[g]),
         .altEn(altEn[g]),
         .altOut(altOut[g]),
         .altOe(altOe[g]),
         .sample(st_ff.pinSample[g]),
         .nxtOut(sliceOut[g]),
         .nxtOe(sliceOe[g]),
         .readVal(readVal[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave, zero wait states
   assign busIdx = haddr[TOP_SHIFT-1:gpio_pkg::IDX_LSB];
   assign busInWindow = (haddr >> TOP_SHIFT) == '0;
   assign addrTaken = hsel && hready && (htrans == gpio_pkg::HTRANS_NONSEQ)
      && (hsize == gpio_pkg::HSIZE_WORD);

   always_comb begin
      logic [3:0] dec;
      dec = 4'h0;
      nxt_st = st_ff;
      nxt_st.pinSample = {portDIn, portCIn, portBIn, portAIn};
      nxt_st.pinOut = sliceOut; // RL2
      nxt_st.pinOe = sliceOe; // RL3
      nxt_st.ready = 1'b1;
      nxt_st.resp = gpio_pkg::HRESP_OKAY;
      nxt_st.rdata = gpio_pkg::RDATA_RESET;
      nxt_st.wrPend = 1'b0;
      // data phase of a write taken last cycle
      if (st_ff.wrPend) begin
         dec = regDecode(st_ff.wrIdx, expandedMode); // RL15
         if (dec[3]) begin
            if (dec[2]) begin
               nxt_st.dir[dec[1:0]] = hwdata[PW-1:0]; // RL3
            end else begin
               nxt_st.latch[dec[1:0]] = hwdata[PW-1:0]; // RL9
            end
         end
      end
      // read data is registered here so it stands in the data phase
      if (addrTaken) begin
         if (hwrite) begin
            nxt_st.wrPend = busInWindow;
            nxt_st.wrIdx = busIdx;
         end else if (busInWindow) begin
            dec = regDecode(busIdx, expandedMode); // RL15
            if (dec[3]) begin
               nxt_st.rdata = {gpio_pkg::RDATA_PAD,
                  dec[2] ? st_ff.dir[dec[1:0]] : readVal[dec[1:0]]}; // RL14
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // latches take no reset: they come up undefined and keep their value on reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff.dir <= {NP{gpio_pkg::DIR_RESET}}; // RL3
         st_ff.pinOut <= {NP{gpio_pkg::OE_RESET}};
         st_ff.pinOe <= {NP{gpio_pkg::OE_RESET}}; // RL4 RL5 RL8 RL11
         st_ff.pinSample <= {NP{gpio_pkg::OE_RESET}};
         st_ff.wrPend <= 1'b0;
         st_ff.wrIdx <= '0;
         st_ff.rdata <= gpio_pkg::RDATA_RESET;
         st_ff.ready <= 1'b1;
         st_ff.resp <= gpio_pkg::HRESP_OKAY;
      end else if (ce) begin
         st_ff <= nxt_st; // RL1
      end
   end

   assign hrdata = st_ff.rdata;
   assign hreadyout = st_ff.ready;
   assign hresp = st_ff.resp;
   assign portAOut = st_ff.pinOut[gpio_pkg::PORT_A];
   assign portAOe = st_ff.pinOe[gpio_pkg::PORT_A];
   assign portBOut = st_ff.pinOut[gpio_pkg::PORT_B];
   assign portBOe = st_ff.pinOe[gpio_pkg::PORT_B];
   assign portCOut = st_ff.pinOut[gpio_pkg::PORT_C];
   assign portCOe = st_ff.pinOe[gpio_pkg::PORT_C];
   assign portDOut = st_ff.pinOut[gpio_pkg::PORT_D];
   assign portDOe = st_ff.pinOe[gpio_pkg::PORT_D];
   assign timerIn = st_ff.pinSample[gpio_pkg::PORT_A];
   assign busDataIn = st_ff.pinSample[gpio_pkg::PORT_C];
   assign serialIn = st_ff.pinSample[gpio_pkg::PORT_D];

   ////////////////////////////////////////////////////////////////////////////
   a_reset_dir_zero: assert property (@(posedge clk) $rose(rst_b) |-> st_ff.dir == '0) // RL3
      else $error("direction registers not zero after reset");

   a_reset_pins_float: assert property (@(posedge clk) $rose(rst_b) |-> // RL5
      (portAOe == '0 && portBOe == '0 && portCOe == '0 && portDOe == '0))
      else $error("pins driven right after reset");

   a_single_chip_inputs: assert property (@(posedge clk) disable iff (!rst_b) // RL8
      ce && !expandedMode && st_ff.dir[gpio_pkg::PORT_B] == '0
      && st_ff.dir[gpio_pkg::PORT_C] == '0 |=> portBOe == '0 && portCOe == '0)
      else $error("second or third port driven without direction in single-chip mode");

   // third port alone, so a set second-port direction cannot mask it
   a_third_port_inputs: assert property (@(posedge clk) disable iff (!rst_b) // RL11
      ce && !expandedMode && st_ff.dir[gpio_pkg::PORT_C] == '0 |=> portCOe == '0)
      else $error("third port driven without direction in single-chip mode");

   // owned bits only: unowned bits show the latch, unknown until first written
   a_timer_owns_pin: assert property (@(posedge clk) disable iff (!rst_b) // RL6
      ce |=> (portAOut & $past(timerEn)) == ($past(timerEn) & $past(timerOut))
      && (portAOe & $past(timerEn)) == ($past(timerEn) & $past(timerOe)))
      else $error("first port drive does not follow timer ownership");

   a_first_port_dir: assert property (@(posedge clk) disable iff (!rst_b) // RL3
      ce |=> (portAOe & ~$past(timerEn))
      == ($past(st_ff.dir[gpio_pkg::PORT_A]) & ~$past(timerEn)))
      else $error("first port enable does not follow direction");

   a_expanded_address: assert property (@(posedge clk) disable iff (!rst_b) // RL7
      ce && expandedMode |=> portBOut == $past(addrHigh) && portBOe == 8'hFF)
      else $error("second port not carrying high address in expanded mode");

   a_expanded_databus: assert property (@(posedge clk) disable iff (!rst_b) // RL10
      ce && expandedMode |=> portCOut == $past(busDataOut)
      && portCOe == $past(busDataOe))
      else $error("third port not carrying data bus in expanded mode");

   // checked per owned bit, as the serial blocks rarely own the whole port
   a_serial_owns_pin: assert property (@(posedge clk) disable iff (!rst_b) // RL12
      ce |=> (portDOut & $past(serialEn)) == ($past(serialEn) & $past(serialOut))
      && (portDOe & $past(serialEn)) == ($past(serialEn) & $past(serialOe)))
      else $error("fourth port drive does not follow serial ownership");

   a_fourth_port_dir: assert property (@(posedge clk) disable iff (!rst_b) // RL13
      ce && serialEn == '0 |=> portDOe == $past(st_ff.dir[gpio_pkg::PORT_D]))
      else $error("fourth port enable does not follow direction");

   a_latch_write: assert property (@(posedge clk) disable iff (!rst_b) // RL2
      ce && st_ff.wrPend && st_ff.wrIdx == gpio_pkg::IDX_A_DATA
      |=> st_ff.latch[gpio_pkg::PORT_A] == $past(hwdata[7:0]))
      else $error("first port latch write lost");

   a_read_mix: assert property (@(posedge clk) disable iff (!rst_b) // RL14
      ce && addrTaken && !hwrite && haddr == 6'h20 |=> hrdata[7:0] ==
      (($past(st_ff.dir[gpio_pkg::PORT_D]) & $past(st_ff.latch[gpio_pkg::PORT_D]))
      | (~$past(st_ff.dir[gpio_pkg::PORT_D]) & $past(st_ff.pinSample[gpio_pkg::PORT_D]))))
      else $error("fourth port read does not mix latch and pins");

   // read data must not linger past its data phase
   a_read_idle: assert property (@(posedge clk) disable iff (!rst_b) // RL14
      ce && !(addrTaken && !hwrite) |=> hrdata == '0)
      else $error("read data present outside a read data phase");

   a_expanded_unmapped: assert property (@(posedge clk) disable iff (!rst_b) // RL15
      ce && expandedMode && addrTaken && !hwrite && haddr == 6'h08 |=> hrdata == '0)
      else $error("second port register visible in expanded mode");

   // the mode is judged in the data phase, so a write there must be dropped
   a_hidden_write: assert property (@(posedge clk) disable iff (!rst_b) // RL10
      ce && expandedMode && st_ff.wrPend && st_ff.wrIdx == gpio_pkg::IDX_C_DIR
      |=> st_ff.dir[gpio_pkg::PORT_C] == $past(st_ff.dir[gpio_pkg::PORT_C]))
      else $error("third port direction written while unmapped");

   a_write_then_dir: assert property (@(posedge clk) disable iff (!rst_b) // RL3
      ce && st_ff.wrPend && st_ff.wrIdx == gpio_pkg::IDX_A_DIR && !timerEn[0]
      ##1 ce |=> portAOe[0] == $past(hwdata[0], 2))
      else $error("direction write did not reach the pin enable");
endmodule // parallel_ports
`default_nettype wire

// >>> rtl/port_slice.sv
`timescale 1ns/1ps
`default_nettype none
module port_slice #(
   parameter int W = 8
) (
   input wire logic [W-1:0] latch, // data latch
   input wire logic [W-1:0] dir, // direction, 1 = output
   input wire logic [W-1:0] altEn, // pin owned by alternate function
   input wire logic [W-1:0] altOut, // alternate function drive level
   input wire logic [W-1:0] altOe, // alternate function drive enable
   input wire logic [W-1:0] sample, // sampled pin level
   output logic [W-1:0] nxtOut, // next pin drive level
   output logic [W-1:0] nxtOe, // next pin drive enable
   output logic [W-1:0] readVal // data register read value
);
   always_comb begin
      // latch still stores while the alternate owns the pin, it just loses the mux
      nxtOut = (altEn & altOut) | (~altEn & latch); // RL2
      nxtOe = (altEn & altOe) | (~altEn & dir); // RL3
      readVal = (dir & latch) | (~dir & sample); // RL14
   end
endmodule // port_slice
`default_nettype wire
